// [mti_regs.vh]
`ifndef MTI_REGS_VH
`define MTI_REGS_VH
// synthesizer increment, tuned for a 4,5 MHz system clock
`define MTI_SYNTH_INC 32'h0003BA6F
`define MTI_TIMER_W 32
`define MTI_TEL_N 2
// command decode addresses
`define MTI_A_SET_ALARM 4'h0
`define MTI_A_START 4'h1
`define MTI_A_STOP 4'h2
`define MTI_A_CLEAR_IRQ 4'h3
`define MTI_A_LATCH_DUR 4'h4
`define MTI_A_FE_CTRL 4'h5
`define MTI_A_TIMER 4'h6
`define MTI_A_DATE_A 4'h7
`define MTI_A_DATE_B 4'h8
`define MTI_A_IRQ 4'h9
`define MTI_A_FE_STATUS 4'hA
`define MTI_A_RUN_STATUS 4'hB
// start command option bits
`define MTI_ST_ALARM_EN 0
`define MTI_ST_SAT_STOP 1
`define MTI_ST_ALARM_IRQ 2
`define MTI_ST_SAT_IRQ 3
`define MTI_ST_CAL_EN 4
// front-end control bits per telescope t: base 4*t
`define MTI_FC_PWR 0
`define MTI_FC_DRV 1
`define MTI_FC_ENA 2
`define MTI_FC_CONF 3
// interrupt register bit positions
`define MTI_IR_ALARM 0
`define MTI_IR_SAT_A 1
`define MTI_IR_SAT_B 2
`define MTI_IR_CERR_A 3
`define MTI_IR_CERR_B 4
`define MTI_IR_LU_A 5
`define MTI_IR_LU_B 6
`define MTI_IR_RUN_ERR_A 7
`define MTI_IR_RUN_ERR_B 8
`define MTI_IR_CAL_LU 9
`define MTI_IR_W 10
// break frame: start + 8 data + 2 stop + 1 extra
`define MTI_BRK_BITS 4'hC
`define MTI_LATCH_DUR_RST 16'h0010
`endif

// [mti_timer_irq.v]
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "mti_regs.vh"
// Overview of operation
// - alarm write halts and zeroes timer
// - start clears/starts timer, opens events, calibration
// - run until alarm or stop, then block
// - timer readable any time, unsynchronised
// - first saturation/latchup/config error dates telescope
// - enabled saturation stops that telescope only
// - latchup or config error always stops telescope
// - datation reads zero until latched
// - run end copies timer to undated latches
// - 32-bit synthesizer adds fixed increment
// - interrupt on alarm, saturation, error, latchup
// - interrupt also sends serial break
// - interrupt once until host clears register
// - alarm sets bit; interrupt only if enabled
// - saturation sets bit; interrupt only if enabled
// - config error rising edge, gated by state
// - raw error/latchup always readable
// - latchup needs minimum duration, gated by power
// - latchup powers down that telescope only, tristates, dates
// - latchup in calibration run is recorded
// - per-telescope propagation status and run errors
// - break is twelve low bits after byte
// - alarm/stop halt timer, value kept
module mti_timer_irq #(
  parameter TW = `MTI_TIMER_W,
  parameter BAUD_DIV = 16'd868,
  parameter LDW = 16
) (
  input wire clk_i,
  input wire reset_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire [1:0] sat_i,
  input wire [1:0] conf_err_i,
  input wire [1:0] latchup_i,
  input wire cal_done_i,
  input wire tx_busy_i,
  output reg [1:0] event_open_o,
  output reg cal_run_o,
  output reg [1:0] fe_power_o,
  output reg [1:0] fe_drive_oe_o,
  output reg external_interrupt_out_o,
  output reg serial_break_n_o,
  output reg break_busy_o
);
  reg [31:0] synth_acc_r;
  reg [TW-1:0] timer_r;
  reg [TW-1:0] alarm_r;
  reg [TW-1:0] date_r [0:1];
  reg [1:0] dated_r;
  reg run_r;
  reg [4:0] opts_r;
  reg [7:0] fe_ctrl_r;
  reg [LDW-1:0] latch_dur_r;
  reg [LDW-1:0] lu_cnt_r [0:1];
  reg [1:0] lu_seen_r;
  reg [1:0] cerr_d_r;
  reg [`MTI_IR_W-1:0] irq_reg_r;
  reg [1:0] brk_st_r;
  reg [3:0] brk_bits_r;
  reg [15:0] brk_div_r;
  reg irq_pend_r;
  wire [32:0] synth_sum;
  wire tick;
  wire alarm_hit;
  wire run_end;
  wire [1:0] sat_ev;
  wire [1:0] cerr_ev;
  wire [1:0] lu_ev;
  wire [1:0] tel_stop;
  wire [`MTI_IR_W-1:0] ir_set;
  wire irq_cause;
  reg [`MTI_IR_W-1:0] ir_nxt;
  integer t;
  genvar g;
  localparam BRK_IDLE = 2'd0;
  localparam BRK_WAIT = 2'd1;
  localparam BRK_SEND = 2'd2;

  function fe_bit;
    input [7:0] ctrl;
    input integer tel;
    input integer pos;
    begin
      fe_bit = ctrl[4*tel+pos];
    end
  endfunction

  assign synth_sum = {1'b0, synth_acc_r} + {1'b0, `MTI_SYNTH_INC};
  assign tick = run_r & synth_sum[32];
  assign alarm_hit = run_r & (timer_r == alarm_r);
  assign run_end = run_r & ((alarm_hit & opts_r[`MTI_ST_ALARM_EN]) | cal_done_i
    | (wr_i & addr_i == `MTI_A_STOP));

  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_tel
      // saturation only counts while events flow into that telescope
      assign sat_ev[g] = event_open_o[g] & sat_i[g];
      assign cerr_ev[g] = conf_err_i[g] & ~cerr_d_r[g] & fe_bit(fe_ctrl_r, g, `MTI_FC_PWR)
        & fe_bit(fe_ctrl_r, g, `MTI_FC_DRV) & fe_bit(fe_ctrl_r, g, `MTI_FC_ENA)
        & ~fe_bit(fe_ctrl_r, g, `MTI_FC_CONF);
      assign lu_ev[g] = latchup_i[g] & ~lu_seen_r[g] & (lu_cnt_r[g] >= latch_dur_r)
        & fe_power_o[g] & fe_drive_oe_o[g];
      assign tel_stop[g] = (sat_ev[g] & opts_r[`MTI_ST_SAT_STOP]) | cerr_ev[g]
        | lu_ev[g];
    end
  endgenerate

  assign ir_set[`MTI_IR_ALARM] = alarm_hit;
  assign ir_set[`MTI_IR_SAT_A] = sat_ev[0];
  assign ir_set[`MTI_IR_SAT_B] = sat_ev[1];
  assign ir_set[`MTI_IR_CERR_A] = cerr_ev[0];
  assign ir_set[`MTI_IR_CERR_B] = cerr_ev[1];
  assign ir_set[`MTI_IR_LU_A] = lu_ev[0];
  assign ir_set[`MTI_IR_LU_B] = lu_ev[1];
  assign ir_set[`MTI_IR_RUN_ERR_A] = run_r & (cerr_ev[0] | lu_ev[0]);
  assign ir_set[`MTI_IR_RUN_ERR_B] = run_r & (cerr_ev[1] | lu_ev[1]);
  assign ir_set[`MTI_IR_CAL_LU] = run_r & opts_r[`MTI_ST_CAL_EN] & (|lu_ev);
  assign irq_cause = (alarm_hit & opts_r[`MTI_ST_ALARM_IRQ])
    | ((|sat_ev) & opts_r[`MTI_ST_SAT_IRQ]) | (|cerr_ev) | (|lu_ev);

  // set wins over a clear arriving in the same cycle
  always @*
  begin
    ir_nxt = irq_reg_r;
    if (wr_i && addr_i == `MTI_A_CLEAR_IRQ)
      ir_nxt = {`MTI_IR_W{1'b0}};
    ir_nxt = ir_nxt | ir_set;
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      synth_acc_r <= 32'h00000000;
      timer_r <= {TW{1'b0}};
      alarm_r <= {TW{1'b0}};
      date_r[0] <= {TW{1'b0}};
      date_r[1] <= {TW{1'b0}};
      dated_r <= 2'b00;
      run_r <= 1'b0;
      opts_r <= 5'h00;
      fe_ctrl_r <= 8'h00;
      latch_dur_r <= `MTI_LATCH_DUR_RST;
      lu_cnt_r[0] <= {LDW{1'b0}};
      lu_cnt_r[1] <= {LDW{1'b0}};
      lu_seen_r <= 2'b00;
      cerr_d_r <= 2'b00;
      irq_reg_r <= {`MTI_IR_W{1'b0}};
      event_open_o <= 2'b00;
      cal_run_o <= 1'b0;
      fe_power_o <= 2'b00;
      fe_drive_oe_o <= 2'b00;
      external_interrupt_out_o <= 1'b0;
      rdata_o <= 32'h00000000;
    end
    else
    begin
      synth_acc_r <= synth_sum[31:0];
      if (tick)
        timer_r <= timer_r + 1'b1;
      irq_reg_r <= ir_nxt;
      cerr_d_r <= conf_err_i;
      for (t = 0; t < 2; t = t + 1)
      begin
        // duration filter: counts while latchup is held high
        if (!latchup_i[t])
        begin
          lu_cnt_r[t] <= {LDW{1'b0}};
          lu_seen_r[t] <= 1'b0;
        end
        else if (lu_cnt_r[t] < latch_dur_r)
          lu_cnt_r[t] <= lu_cnt_r[t] + 1'b1;
        else
          lu_seen_r[t] <= 1'b1;
        if (tel_stop[t])
          event_open_o[t] <= 1'b0;
        if ((sat_ev[t] | cerr_ev[t] | lu_ev[t] | run_end) && !dated_r[t])
        begin
          date_r[t] <= timer_r;
          dated_r[t] <= 1'b1;
        end
        if (lu_ev[t])
        begin
          fe_power_o[t] <= 1'b0;
          fe_drive_oe_o[t] <= 1'b0;
        end
      end
      if (wr_i && addr_i == `MTI_A_FE_CTRL)
      begin
        fe_ctrl_r <= wdata_i[7:0];
        fe_power_o <= {wdata_i[4+`MTI_FC_PWR], wdata_i[`MTI_FC_PWR]};
        fe_drive_oe_o <= {wdata_i[4+`MTI_FC_DRV], wdata_i[`MTI_FC_DRV]};
      end
      if (wr_i && addr_i == `MTI_A_LATCH_DUR)
        latch_dur_r <= wdata_i[LDW-1:0];
      if (wr_i && addr_i == `MTI_A_SET_ALARM)
      begin
        alarm_r <= wdata_i[TW-1:0];
        timer_r <= {TW{1'b0}};
        run_r <= 1'b0;
        event_open_o <= 2'b00;
        cal_run_o <= 1'b0;
      end
      else if (wr_i && addr_i == `MTI_A_START)
      begin
        opts_r <= wdata_i[4:0];
        timer_r <= {TW{1'b0}};
        synth_acc_r <= 32'h00000000;
        run_r <= 1'b1;
        event_open_o <= 2'b11;
        cal_run_o <= wdata_i[`MTI_ST_CAL_EN];
        dated_r <= 2'b00;
        date_r[0] <= {TW{1'b0}};
        date_r[1] <= {TW{1'b0}};
      end
      else if (run_end)
      begin
        run_r <= 1'b0;
        event_open_o <= 2'b00;
        cal_run_o <= 1'b0;
      end
      // one interrupt per burst; later causes only land in the register
      if (wr_i && addr_i == `MTI_A_CLEAR_IRQ)
        external_interrupt_out_o <= 1'b0;
      if (irq_cause && !external_interrupt_out_o)
        external_interrupt_out_o <= 1'b1;
      rdata_o <= 32'h00000000;
      if (rd_i)
      begin
        case (addr_i)
          `MTI_A_TIMER: rdata_o <= timer_r;
          `MTI_A_DATE_A: rdata_o <= date_r[0];
          `MTI_A_DATE_B: rdata_o <= date_r[1];
          `MTI_A_SET_ALARM: rdata_o <= alarm_r;
          `MTI_A_IRQ: rdata_o <= {{(32-`MTI_IR_W){1'b0}}, irq_reg_r};
          `MTI_A_FE_STATUS: rdata_o <= {24'h000000, fe_power_o, fe_drive_oe_o,
            latchup_i, conf_err_i};
          `MTI_A_RUN_STATUS: rdata_o <= {28'h0000000, cal_run_o, event_open_o, run_r};
          `MTI_A_FE_CTRL: rdata_o <= {24'h000000, fe_ctrl_r};
          `MTI_A_LATCH_DUR: rdata_o <= {{(32-LDW){1'b0}}, latch_dur_r};
          default: rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // break generator: waits for the byte in flight, then twelve low bit times
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      brk_st_r <= BRK_IDLE;
      brk_bits_r <= 4'h0;
      brk_div_r <= 16'h0000;
      irq_pend_r <= 1'b0;
      serial_break_n_o <= 1'b1;
      break_busy_o <= 1'b0;
    end
    else
    begin
      if (irq_cause && !external_interrupt_out_o)
        irq_pend_r <= 1'b1;
      case (brk_st_r)
        BRK_IDLE:
        begin
          if (irq_pend_r)
          begin
            irq_pend_r <= 1'b0;
            brk_st_r <= BRK_WAIT;
            break_busy_o <= 1'b1;
          end
        end
        BRK_WAIT:
        begin
          if (!tx_busy_i)
          begin
            brk_st_r <= BRK_SEND;
            brk_bits_r <= `MTI_BRK_BITS;
            brk_div_r <= BAUD_DIV;
            serial_break_n_o <= 1'b0;
          end
        end
        BRK_SEND:
        begin
          if (brk_div_r > 16'h0001)
            brk_div_r <= brk_div_r - 16'h0001;
          else if (brk_bits_r > 4'h1)
          begin
            brk_div_r <= BAUD_DIV;
            brk_bits_r <= brk_bits_r - 4'h1;
          end
          else
          begin
            brk_st_r <= BRK_IDLE;
            serial_break_n_o <= 1'b1;
            break_busy_o <= 1'b0;
          end
        end
        default: brk_st_r <= BRK_IDLE;
      endcase
    end
  end
endmodule // mti_timer_irq
`default_nettype wire

// [mti_timer_irq_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mti_regs.vh"
module mti_timer_irq_sva #(
  parameter BAUD_DIV = 16'd868
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] sat_i,
  input wire logic [1:0] conf_err_i,
  input wire logic [1:0] latchup_i,
  input wire logic cal_done_i,
  input wire logic tx_busy_i,
  input wire logic [1:0] event_open_o,
  input wire logic cal_run_o,
  input wire logic [1:0] fe_power_o,
  input wire logic [1:0] fe_drive_oe_o,
  input wire logic external_interrupt_out_o,
  input wire logic serial_break_n_o,
  input wire logic break_busy_o
);
  logic [31:0] lo_cnt_r;
  // counts low cycles of the break line so the frame length can be judged at its end
  always_ff @(posedge clk_i)
  begin
    if (reset_i || serial_break_n_o)
      lo_cnt_r <= 32'h0;
    else
      lo_cnt_r <= lo_cnt_r + 32'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  start_open_a: assert property (wr_i && addr_i == `MTI_A_START |=> event_open_o == 2'h3)
    else $error("events not opened by start");
  stop_close_a: assert property (wr_i && addr_i == `MTI_A_STOP |=> event_open_o == 2'h0)
    else $error("events still open after stop");
  stay_closed_a: assert property (event_open_o == 2'h0 && !(wr_i && addr_i == `MTI_A_START)
    |=> event_open_o == 2'h0)
    else $error("events reopened without start");
  read_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  irq_hold_a: assert property (external_interrupt_out_o && !(wr_i && addr_i == `MTI_A_CLEAR_IRQ)
    |=> external_interrupt_out_o)
    else $error("interrupt dropped without clear");
  break_follow_a: assert property ($rose(external_interrupt_out_o) |-> ##[0:2] break_busy_o)
    else $error("no break queued with interrupt");
  break_wait_a: assert property (tx_busy_i && serial_break_n_o |=> serial_break_n_o)
    else $error("break started over a busy byte");
  break_len_a: assert property ($rose(serial_break_n_o) |-> lo_cnt_r == 12 * BAUD_DIV)
    else $error("break frame length wrong");
  cal_end_a: assert property (cal_done_i |=> !cal_run_o && event_open_o == 2'h0)
    else $error("calibration completion did not end run");
endmodule // mti_timer_irq_sva
bind mti_timer_irq mti_timer_irq_sva #(.BAUD_DIV(BAUD_DIV)) chk_u (.*);
`default_nettype wire

// [mti_link_model.sv]
`timescale 1ns/100ps
`default_nettype none
// far-side byte transmitter: busy for one ten-bit byte per send pulse
module mti_link_model #(
  parameter BAUD_DIV = 4
) (
  input wire logic clk_i,
  input wire logic send_i,
  output logic tx_busy_o
);
  int cnt_r = 0;
  assign tx_busy_o = (cnt_r != 0);
  // a byte already on the wire must finish before a break may go out
  always @(posedge clk_i)
  begin
    if (send_i)
      cnt_r <= 10 * BAUD_DIV;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  end
endmodule // mti_link_model
`default_nettype wire

// [measurement_timer_interrupt_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mti_regs.vh"
module measurement_timer_interrupt_bench;
  logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, cal_done_i = 0, send = 0, tx_busy;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [1:0] sat_i = 2'h0, conf_err_i = 2'h0, latchup_i = 2'h0;
  logic [1:0] event_open_o, fe_power_o, fe_drive_oe_o;
  logic cal_run_o, irq_o, brk_n, brk_busy;
  int err_total = 0, checks_done = 0, i;
  always #10 clk_i = ~clk_i;
  mti_timer_irq #(.BAUD_DIV(16'd4)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sat_i(sat_i),
    .conf_err_i(conf_err_i), .latchup_i(latchup_i), .cal_done_i(cal_done_i),
    .tx_busy_i(tx_busy), .event_open_o(event_open_o), .cal_run_o(cal_run_o),
    .fe_power_o(fe_power_o), .fe_drive_oe_o(fe_drive_oe_o),
    .external_interrupt_out_o(irq_o), .serial_break_n_o(brk_n), .break_busy_o(brk_busy));
  mti_link_model #(.BAUD_DIV(4)) host_u (.clk_i(clk_i), .send_i(send), .tx_busy_o(tx_busy));
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    checks_done++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  end
  endtask
  task tmo;
  begin
    err_total++;
    print_verdict;
  end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
  begin
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
  begin
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  end
  endtask
  task brk_done;
  begin
    for (i = 0; i < 400 && (brk_busy !== 1'b0); i++) @(posedge clk_i) #1;
    if (brk_busy !== 1'b0) tmo;
    chk(brk_n, 1'b1);
  end
  endtask
  task t_alarm;
  begin
    rd(`MTI_A_DATE_A, 32'h0);
    rd(4'hF, 32'h0);
    wr(`MTI_A_SET_ALARM, 32'h2);
    rd(`MTI_A_TIMER, 32'h0);
    wr(`MTI_A_START, 32'h5);
    #1 chk(event_open_o, 2'h3);
    for (i = 0; i < 60000 && event_open_o != 2'h0; i++) @(posedge clk_i) #1;
    if (event_open_o !== 2'h0) tmo;
    repeat (3) @(posedge clk_i);
    rd(`MTI_A_TIMER, 32'h2);
    rd(`MTI_A_DATE_A, 32'h2);
    rd(`MTI_A_DATE_B, 32'h2);
    rd(`MTI_A_IRQ, 32'h1);
    chk(irq_o, 1'b1);
    brk_done;
    $display("test alarm done");
  end
  endtask
  task t_sat;
  begin
    wr(`MTI_A_CLEAR_IRQ, 32'h0);
    rd(`MTI_A_IRQ, 32'h0);
    chk(irq_o, 1'b0);
    wr(`MTI_A_START, 32'h2);
    sat_i <= 2'h1;
    repeat (8) @(posedge clk_i);
    #1 chk(event_open_o, 2'h2);
    chk(irq_o, 1'b0);
    rd(`MTI_A_IRQ, 32'h2);
    wr(`MTI_A_STOP, 32'h0);
    sat_i <= 2'h0;
    #1 chk(event_open_o, 2'h0);
    $display("test saturation done");
  end
  endtask
  task t_latchup;
  begin
    wr(`MTI_A_CLEAR_IRQ, 32'h0);
    wr(`MTI_A_FE_CTRL, 32'h77);
    #1 chk(fe_power_o, 2'h3);
    @(posedge clk_i);
    latchup_i <= 2'h2;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    for (i = 0; i < 80 && fe_power_o[1] !== 1'b0; i++) @(posedge clk_i) #1;
    if (fe_power_o[1] !== 1'b0) tmo;
    chk(fe_drive_oe_o, 2'h1);
    rd(`MTI_A_FE_STATUS, 32'h58);
    rd(`MTI_A_IRQ, 32'h40);
    chk(irq_o, 1'b1);
    brk_done;
    latchup_i <= 2'h0;
    $display("test latchup done");
  end
  endtask
  task t_conf;
  begin
    wr(`MTI_A_CLEAR_IRQ, 32'h0);
    wr(`MTI_A_FE_CTRL, 32'hF);
    conf_err_i <= 2'h1;
    repeat (6) @(posedge clk_i);
    rd(`MTI_A_IRQ, 32'h0);
    conf_err_i <= 2'h0;
    wr(`MTI_A_FE_CTRL, 32'h7);
    conf_err_i <= 2'h1;
    repeat (6) @(posedge clk_i);
    rd(`MTI_A_IRQ, 32'h8);
    conf_err_i <= 2'h0;
    brk_done;
    $display("test config error done");
  end
  endtask
  task t_cal;
  begin
    wr(`MTI_A_FE_CTRL, 32'h77);
    wr(`MTI_A_CLEAR_IRQ, 32'h0);
    wr(`MTI_A_START, 32'h10);
    rd(`MTI_A_RUN_STATUS, 32'hF);
    @(posedge clk_i);
    latchup_i <= 2'h1;
    for (i = 0; i < 80 && fe_power_o[0] !== 1'b0; i++) @(posedge clk_i) #1;
    if (fe_power_o[0] !== 1'b0) tmo;
    chk(event_open_o, 2'h2);
    rd(`MTI_A_IRQ, 32'h2A0);
    @(posedge clk_i);
    cal_done_i <= 1'b1;
    @(posedge clk_i);
    cal_done_i <= 1'b0;
    #1 chk(event_open_o, 2'h0);
    chk(cal_run_o, 1'b0);
    rd(`MTI_A_RUN_STATUS, 32'h0);
    brk_done;
    latchup_i <= 2'h0;
    $display("test calibration done");
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_alarm;
    t_sat;
    t_latchup;
    t_conf;
    t_cal;
    print_verdict;
  end
endmodule // measurement_timer_interrupt_bench
`default_nettype wire
